// [logic/wwdt_pkg.sv]
// constants and state types of the windowed watchdog timer
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package wwdt_pkg;

  // apb register byte offsets
  localparam logic [11:0] OFS_CLEAR  = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_MSS    = 12'h008;
  localparam logic [11:0] OFS_XSS    = 12'h00C;

  // option byte field positions
  localparam int OPT_RUN_BIT  = 4;
  localparam int OPT_OTS_LO   = 1;
  localparam int OPT_WIN_LO   = 5;
  localparam int OPT_LSO_STOP = 0;

  // reset values and codes
  localparam logic [7:0]  CLEAR_CODE = 8'hAC;
  localparam logic [7:0]  MSS_RST    = 8'h00;
  localparam logic [7:0]  XSS_RST    = 8'h00;
  localparam logic [15:0] DATA_EXEMPT = 16'hFB00;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;

  // fault cause codes shown in status
  localparam logic [2:0] CAUSE_NONE  = 3'h0;
  localparam logic [2:0] CAUSE_OVF   = 3'h1;
  localparam logic [2:0] CAUSE_WIN   = 3'h2;
  localparam logic [2:0] CAUSE_CODE  = 3'h3;
  localparam logic [2:0] CAUSE_BIT   = 3'h4;
  localparam logic [2:0] CAUSE_FETCH = 3'h5;
  localparam logic [2:0] CAUSE_DATA  = 3'h6;

  // slow tick rate; kept fast so the shortest overflow is a few
  // thousand clocks, at the cost of a scaled time base
  localparam int PCLK_HZ  = 40_000_000;
  localparam int LSO_HZ   = 8_000_000;
  localparam int LSO_DIV  = PCLK_HZ / LSO_HZ;

  typedef enum logic [1:0] {
    WW_CAPTURE,
    WW_RUN,
    WW_OFF,
    WW_FAULT
  } wwdt_state_t;

endpackage : wwdt_pkg

// [logic/wwdt_tick.sv]
// slow oscillator tick divider for the watchdog counter
`timescale 1ns/1ps
module wwdt_tick
  import wwdt_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic run,
  input  wire logic restart,
  // tick out
  output logic      tick
);

  typedef struct packed {
    logic [15:0] div;
    logic        tick;
  } wwdt_tick_st_t;

  localparam logic [15:0] DIV_LAST = 16'(LSO_DIV - 1);

  wwdt_tick_st_t s_r;
  wwdt_tick_st_t s_nxt;

  // restart realigns the phase so a clear shifts timing by under a tick
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (restart || !run) begin
      s_nxt.div = 16'h0000;
    end else if (s_r.div == DIV_LAST) begin
      s_nxt.div = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule : wwdt_tick

// [logic/wwdt_top.sv]
// windowed watchdog timer with apb registers and access checking
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
module wwdt_top
  import wwdt_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // non-volatile option byte and sidebands from the core
  input  wire logic [7:0]  option_byte,
  input  wire logic        bit_manip,
  input  wire logic        stop_mode,
  // core access monitor
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        data_valid,
  input  wire logic [15:0] data_addr,
  // reset request toward system reset logic
  output logic             wdt_reset_req
);

  //----------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------
  typedef struct packed {
    wwdt_state_t state;
    logic [7:0]  opt;
    logic [15:0] cnt;
    logic        first_done;
    logic [7:0]  mss;
    logic [7:0]  xss;
    logic [2:0]  cause;
    logic        rst_req;
    logic [31:0] prdata;
    logic        slverr;
  } wwdt_st_t;

  wwdt_st_t s_r;
  wwdt_st_t s_nxt;

  //----------------------------------------------------------------------
  // decode helpers
  //----------------------------------------------------------------------
  // legal program area: 1 kb blocks from address zero
  function automatic logic in_mem(input logic [15:0] a,
                                  input logic [7:0]  m,
                                  input logic [7:0]  x);
    logic [16:0] top;
    top = {1'b0, m[5:0], 10'h000} + {1'b0, x[5:0], 10'h000};
    in_mem = ({1'b0, a} < top);
  endfunction : in_mem

  function automatic logic map_hit(input logic [11:0] a);
    map_hit = (a == OFS_CLEAR) || (a == OFS_STATUS) ||
              (a == OFS_MSS) || (a == OFS_XSS);
  endfunction : map_hit

  //----------------------------------------------------------------------
  // derived timing
  //----------------------------------------------------------------------
  logic [2:0]  ots;
  logic [1:0]  win;
  logic [15:0] limit;
  logic [15:0] quarter;
  logic [15:0] open_from;
  logic        running;
  logic        tick;
  logic        gate_off;

  assign ots = s_r.opt[OPT_OTS_LO +: 3];
  assign win = s_r.opt[OPT_WIN_LO +: 2];
  // longest choice reaches the full 16-bit count
  assign limit = CNT_MAX >> (3'd7 - ots);
  assign quarter = (limit >> 2) + 16'h0001;
  assign running = (s_r.state == WW_RUN);

  // window opens for the last 1, 2, 3 or 4 quarters of the period
  always_comb begin
    case (win)
      2'b00:   open_from = (quarter << 1) + quarter;
      2'b01:   open_from = quarter << 1;
      2'b10:   open_from = quarter;
      default: open_from = 16'h0000;
    endcase
  end

  // slow clock stops in stop mode only when the option lets it
  assign gate_off = stop_mode && s_r.opt[OPT_LSO_STOP];

  //----------------------------------------------------------------------
  // apb transfer decode
  //----------------------------------------------------------------------
  logic setup_ph;
  logic access_wr;
  logic clr_wr;
  logic clr_ok;
  logic win_closed;

  assign setup_ph = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign clr_wr = access_wr && (paddr == OFS_CLEAR) && running;
  assign win_closed = s_r.first_done && (s_r.cnt < open_from);
  assign clr_ok = clr_wr && !bit_manip && !win_closed &&
                  (pwdata[7:0] == CLEAR_CODE);

  wwdt_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (running && !gate_off),
    .restart (clr_ok),
    .tick    (tick)
  );

  //----------------------------------------------------------------------
  // fault detection
  //----------------------------------------------------------------------
  logic       fault;
  logic [2:0] fault_cause;

  // earlier entries win when several faults meet in one cycle
  always_comb begin
    fault = 1'b1;
    fault_cause = CAUSE_NONE;
    if (clr_wr && bit_manip) begin
      fault_cause = CAUSE_BIT;
    end else if (clr_wr && (pwdata[7:0] != CLEAR_CODE)) begin
      fault_cause = CAUSE_CODE;
    end else if (clr_wr && win_closed) begin
      fault_cause = CAUSE_WIN;
    end else if (running && fetch_valid &&
                 !in_mem(fetch_addr, s_r.mss, s_r.xss)) begin
      fault_cause = CAUSE_FETCH;
    end else if (running && data_valid && (data_addr < DATA_EXEMPT) &&
                 !in_mem(data_addr, s_r.mss, s_r.xss)) begin
      fault_cause = CAUSE_DATA;
    end else if (running && tick && (s_r.cnt == limit) && !clr_ok) begin
      fault_cause = CAUSE_OVF;
    end else begin
      fault = 1'b0;
    end
  end

  //----------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    case (s_r.state)
      WW_CAPTURE: begin
        // option byte caught on the first edge after release
        s_nxt.opt = option_byte;
        s_nxt.state = option_byte[OPT_RUN_BIT] ? WW_RUN
                                               : WW_OFF;
      end
      WW_RUN: begin
        if (fault) begin
          s_nxt.state = WW_FAULT;
          s_nxt.rst_req = 1'b1;
          s_nxt.cause = fault_cause;
        end else if (clr_ok) begin
          s_nxt.cnt = 16'h0000;
          s_nxt.first_done = 1'b1;
        end else if (tick) begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
        end
      end
      WW_OFF: begin
        s_nxt.cnt = 16'h0000;
      end
      WW_FAULT: begin
        // held until the system resets this block
        s_nxt.rst_req = 1'b1;
      end
      default: begin
        s_nxt.state = WW_FAULT;
        s_nxt.rst_req = 1'b1;
      end
    endcase

    // software writes to the region size registers
    if (access_wr && (paddr == OFS_MSS)) begin
      s_nxt.mss = pwdata[7:0];
    end
    if (access_wr && (paddr == OFS_XSS)) begin
      s_nxt.xss = pwdata[7:0];
    end

    // read data and error prepared in setup, shown in access
    if (setup_ph) begin
      s_nxt.slverr = !map_hit(paddr);
      case (paddr)
        OFS_STATUS: s_nxt.prdata = {s_r.cnt, 8'h00, s_r.first_done,
                                    s_r.rst_req, s_r.state,
                                    1'b0, s_r.cause};
        OFS_MSS:    s_nxt.prdata = {24'h000000, s_r.mss};
        OFS_XSS:    s_nxt.prdata = {24'h000000, s_r.xss};
        default:    s_nxt.prdata = 32'h00000000;
      endcase
    end
  end

  //----------------------------------------------------------------------
  // state register
  //----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '{state:      WW_CAPTURE,
               opt:        8'h00,
               cnt:        16'h0000,
               first_done: 1'b0,
               mss:        MSS_RST,
               xss:        XSS_RST,
               cause:      CAUSE_NONE,
               rst_req:    1'b0,
               prdata:     32'h00000000,
               slverr:     1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // zero wait state: the answer is ready in every access cycle
  assign pready = 1'b1;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.slverr && psel && penable;
  assign wdt_reset_req = s_r.rst_req;

  //----------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // every check below is masked while presetn is low
  a_run_mode: assert property (
    (s_r.state == WW_CAPTURE) |=>
      (s_r.state == (s_r.opt[OPT_RUN_BIT] ? WW_RUN : WW_OFF)))
    else $error("mode does not follow option run bit");

  a_auto_start: assert property (
    (s_r.state == WW_CAPTURE) && option_byte[OPT_RUN_BIT] |=>
      running ##1 (s_r.state != WW_CAPTURE))
    else $error("counter did not start after release");

  a_clear_zero: assert property (
    clr_ok && !fault |=> (s_r.cnt == 16'h0000) && s_r.first_done)
    else $error("valid clear did not zero the counter");

  a_window_closed: assert property (
    running && clr_wr && win_closed |=> wdt_reset_req)
    else $error("closed window clear gave no reset");

  a_first_free: assert property (
    running && clr_wr && !s_r.first_done && !bit_manip &&
    (pwdata[7:0] == CLEAR_CODE) |=> !wdt_reset_req)
    else $error("first clear was window checked");

  a_overflow_rst: assert property (
    running && tick && (s_r.cnt == limit) && !clr_wr |=>
      wdt_reset_req && (s_r.cause != CAUSE_NONE))
    else $error("overflow gave no reset");

  a_last_clear: assert property (
    running && tick && (s_r.cnt == limit) && clr_ok &&
    !fetch_valid && !data_valid |=> !wdt_reset_req && (s_r.cnt == 0))
    else $error("clear on last count lost");

  a_bit_op: assert property (
    clr_wr && bit_manip |=> wdt_reset_req && (s_r.cause == CAUSE_BIT))
    else $error("bit operation on clear gave no reset");

  a_bad_code: assert property (
    clr_wr && !bit_manip && (pwdata[7:0] != CLEAR_CODE) |=>
      wdt_reset_req && (s_r.cause == CAUSE_CODE))
    else $error("wrong clear code gave no reset");

  a_fetch_check: assert property (
    running && !clr_wr && fetch_valid &&
    !in_mem(fetch_addr, s_r.mss, s_r.xss) |=>
      wdt_reset_req && (s_r.cause == CAUSE_FETCH))
    else $error("illegal fetch gave no reset");

  a_data_exempt: assert property (
    running && !clr_wr && !fetch_valid && !tick && data_valid &&
    (data_addr >= DATA_EXEMPT) |=> !wdt_reset_req)
    else $error("exempt data access gave a reset");

  a_stop_hold: assert property (
    running && gate_off && !clr_wr |=> $stable(s_r.cnt))
    else $error("counter moved with slow clock stopped");

  a_req_held: assert property (
    wdt_reset_req |=> wdt_reset_req [*3])
    else $error("reset request dropped before reset");

  a_tick_gap: assert property (
    tick |=> !tick [*2])
    else $error("slow ticks closer than the divider allows");

  a_off_quiet: assert property (
    (s_r.state == WW_OFF) |=> !wdt_reset_req && (s_r.cnt == 0))
    else $error("disabled watchdog active");

  // open-window clears, data faults, gating and the held fault
  a_open_clear: assert property (
    clr_ok && !fault |=> !wdt_reset_req)
    else $error("clear in open window gave a reset");

  a_data_check: assert property (
    running && !clr_wr && !fetch_valid && data_valid &&
    (data_addr < DATA_EXEMPT) && !in_mem(data_addr, s_r.mss, s_r.xss) |=>
      wdt_reset_req && (s_r.cause == CAUSE_DATA))
    else $error("illegal data access gave no reset");

  a_tick_gate: assert property (
    !running || gate_off |=> !tick)
    else $error("slow tick while its clock is gated");

  a_fault_stays: assert property (
    (s_r.state == WW_FAULT) |=> (s_r.state == WW_FAULT))
    else $error("fault state left without a reset");

  a_req_cause: assert property (
    wdt_reset_req |-> (s_r.cause != CAUSE_NONE))
    else $error("reset request without a recorded cause");

  // main scenarios the bench should reach
  c_good_clear: cover property (running ##1 clr_ok ##1 running);
  c_window_fault: cover property (clr_wr && win_closed);
  c_overflow: cover property (
    running && tick && (s_r.cnt == limit) ##1 wdt_reset_req);
  c_fetch_fault: cover property (s_r.cause == CAUSE_FETCH);
  c_data_fault: cover property (s_r.cause == CAUSE_DATA);

endmodule : wwdt_top

// [tb/wwdt_cpu_model.sv]
// cpu core model: apb master, access feed and stop-mode sideband
`timescale 1ns/1ps
module wwdt_cpu_model (
  // clock
  input  wire logic        pclk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // sidebands and access feed
  output logic             bit_manip,
  output logic             stop_mode,
  output logic             fetch_valid,
  output logic [15:0]      fetch_addr,
  output logic             data_valid,
  output logic [15:0]      data_addr
);
  // idle bus at time zero
  initial begin
    {psel, penable, pwrite, bit_manip, stop_mode} = '0;
    {fetch_valid, data_valid} = '0;
    {paddr, pwdata, fetch_addr, data_addr} = '0;
  end

  // one transfer, held until pready is seen; clear code and its timing
  // are chosen by the caller
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic bm,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel      <= 1'b1;
    pwrite    <= wr;
    paddr     <= a;
    pwdata    <= d;
    bit_manip <= bm;
    @(posedge pclk);
    penable   <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel      <= 1'b0;
    penable   <= 1'b0;
    bit_manip <= 1'b0;
    // released lines show inverted values so stale data never matches
    paddr     <= ~a;
    pwdata    <= ~d;
  endtask : xfer

  // one fetch or data access lasting a single cycle
  task automatic access(input logic is_fetch, input logic [15:0] a);
    @(posedge pclk);
    fetch_valid <= is_fetch;
    data_valid  <= !is_fetch;
    fetch_addr  <= a;
    data_addr   <= a;
    @(posedge pclk);
    fetch_valid <= 1'b0;
    data_valid  <= 1'b0;
    fetch_addr  <= ~a;
    data_addr   <= ~a;
  endtask : access
endmodule : wwdt_cpu_model

// [tb/wwdt_tb_top.sv]
// self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
module wwdt_tb_top
  import wwdt_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        bit_manip, stop_mode, fetch_valid, data_valid;
  logic        wdt_reset_req, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fetch_addr, data_addr;
  logic [7:0]  option_byte;
  int          fails, tests_run;

  // ----------------------------------------------------------------
  // clock, reset and instances
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  wwdt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .option_byte(option_byte), .bit_manip(bit_manip),
    .stop_mode(stop_mode), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .data_valid(data_valid),
    .data_addr(data_addr), .wdt_reset_req(wdt_reset_req));

  wwdt_cpu_model i_cpu (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bit_manip(bit_manip),
    .stop_mode(stop_mode), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .data_valid(data_valid),
    .data_addr(data_addr));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t ns %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // the request is sticky, so every test starts from a fresh reset
  task automatic restart(input logic [7:0] opt);
    @(posedge pclk);
    presetn     <= 1'b0;
    option_byte <= opt;
    repeat (4) @(posedge pclk);
    presetn     <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : restart

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic bm = 1'b0);
    i_cpu.xfer(1'b1, a, {24'h0, d}, bm, rd, err);
  endtask : wr

  task automatic rd_reg(input logic [11:0] a);
    i_cpu.xfer(1'b0, a, 32'h0, 1'b0, rd, err);
  endtask : rd_reg

  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : waitc

  task automatic req_is(input logic e);
    check({31'h0, wdt_reset_req}, {31'h0, e}, "reset request");
  endtask : req_is

  task automatic cause_is(input logic [2:0] c);
    rd_reg(OFS_STATUS);
    check({29'h0, rd[2:0]}, {29'h0, c}, "fault cause");
  endtask : cause_is

  // polling is bounded by the watchdog process
  task automatic wait_count(input logic [15:0] n);
    do rd_reg(OFS_STATUS); while (rd[31:16] !== n);
  endtask : wait_count

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_off();
    restart(8'h02);
    rd_reg(OFS_MSS);
    check(rd, {24'h0, MSS_RST}, "mss reset value");
    rd_reg(OFS_XSS);
    check(rd, {24'h0, XSS_RST}, "xss reset value");
    rd_reg(12'h010);
    check({31'h0, err}, 32'h1, "unmapped error");
    i_cpu.access(1'b1, 16'h8000);
    wr(OFS_CLEAR, 8'h55);
    waitc(800);
    req_is(1'b0); // disabled: no counting, no detection
    rd_reg(OFS_STATUS);
    check({30'h0, rd[5:4]}, 32'h2, "off state");
    $display("done: off");
  endtask : test_off

  task automatic test_ovf();
    int span;
    for (int t = 0; t < 2; t++) begin
      span = ((int'(CNT_MAX) >> (7 - t)) + 1) * LSO_DIV;
      restart(8'h10 | 8'(t << 1));
      i_cpu.stop_mode <= 1'b1; // stop alone must not freeze it
      waitc(span - 30);
      req_is(1'b0); // not early, cleared by reset
      waitc(60);
      req_is(1'b1);
      cause_is(CAUSE_OVF);
      waitc(50);
      req_is(1'b1); // held until reset
      i_cpu.stop_mode <= 1'b0;
    end
    restart(8'h11);
    i_cpu.stop_mode <= 1'b1;
    waitc(1000);
    req_is(1'b0); // frozen while stoppable osc is stopped
    i_cpu.stop_mode <= 1'b0;
    waitc(((int'(CNT_MAX) >> 7) + 1) * LSO_DIV + 30);
    req_is(1'b1);
    $display("done: overflow");
  endtask : test_ovf

  task automatic test_window();
    for (int w = 0; w < 4; w++) begin
      restart(8'h10 | 8'(w << 5)); // limit 511, open 384, 256, 128, 0
      wait_count(16'h0002);
      wr(OFS_CLEAR, CLEAR_CODE); // first clear never window checked
      rd_reg(OFS_STATUS);
      check({16'h0, rd[31:16]}, 32'h0, "count after clear");
      wait_count(16'h00C8);
      wr(OFS_CLEAR, CLEAR_CODE);
      waitc(2);
      req_is(w < 2); // closed at count 200 for 0 and 1
      if (w < 2) cause_is(CAUSE_WIN);
    end
    wait_count(16'((int'(CNT_MAX) >> 7) - 1));
    wr(OFS_CLEAR, CLEAR_CODE);
    rd_reg(OFS_STATUS);
    check({16'h0, rd[31:16]}, 32'h0, "last count clear");
    waitc(600);
    req_is(1'b0); // restarted from zero
    $display("done: window");
  endtask : test_window

  task automatic test_code();
    logic [7:0] codes[4] = '{8'h00, 8'hAD, 8'h2C, 8'hFF};
    foreach (codes[i]) begin
      restart(8'h12);
      wr(OFS_CLEAR, codes[i]);
      waitc(2);
      req_is(1'b1); // wrong code
      cause_is(CAUSE_CODE);
    end
    restart(8'h12);
    wr(OFS_CLEAR, CLEAR_CODE, 1'b1);
    waitc(2);
    req_is(1'b1); // single-bit write
    cause_is(CAUSE_BIT);
    $display("done: codes");
  endtask : test_code

  task automatic test_access();
    restart(8'h12);
    wr(OFS_MSS, 8'h01); // legal below 0400H
    i_cpu.access(1'b1, 16'h03FF);
    i_cpu.access(1'b0, 16'hFB00);
    i_cpu.access(1'b0, 16'hFFFF);
    waitc(2);
    req_is(1'b0); // legal and exempt places
    i_cpu.access(1'b1, 16'h0400);
    waitc(2);
    req_is(1'b1);
    cause_is(CAUSE_FETCH);
    restart(8'h12);
    wr(OFS_XSS, 8'h01);
    i_cpu.access(1'b0, 16'h03FF);
    i_cpu.access(1'b0, 16'hFAFF);
    waitc(2);
    req_is(1'b1); // just below the exempt range
    cause_is(CAUSE_DATA);
    $display("done: access");
  endtask : test_access

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // whole run needs about 20000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    $display("[ERR] %0t ns run did not finish", $time);
    end_of_test();
  end

  initial begin
    presetn = 1'b0;
    option_byte = 8'h00;
    test_off();
    test_ovf();
    test_window();
    test_code();
    test_access();
    end_of_test();
  end
endmodule : wwdt_tb_top
